// ===== acc_defines.vh
// Constants for the converter control block
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
`define ACC_IDX_TIMING     12'h0ef
`define ACC_IDX_CHANNEL    12'h0d8
`define ACC_IDX_DATA_LOW   12'h0d9
`define ACC_IDX_DATA_HIGH  12'h0da
// Byte address is four times the index, one aligned word each
`define ACC_OFF_TIMING     (`ACC_IDX_TIMING << 2)
`define ACC_OFF_CHANNEL    (`ACC_IDX_CHANNEL << 2)
`define ACC_OFF_DATA_LOW   (`ACC_IDX_DATA_LOW << 2)
`define ACC_OFF_DATA_HIGH  (`ACC_IDX_DATA_HIGH << 2)
`define ACC_OFF_CAL_OFFSET 12'h100
`define ACC_OFF_CAL_GAIN   12'h104
`define ACC_OFF_IRQ_STATUS 12'h108
`define ACC_OFF_IRQ_MASK   12'h10c
`define ACC_OFF_DMA_ADDR   12'h110
`define ACC_OFF_DMA_COUNT  12'h114
`define ACC_TIMING_RESET   8'h20
`define ACC_CHANNEL_RESET  8'h00
`define ACC_CAL_OFFSET_RST 12'h800
`define ACC_CAL_GAIN_RST   12'h800
`define ACC_MODE_HI        7
`define ACC_MODE_LO        6
`define ACC_CLKDIV_HI      5
`define ACC_CLKDIV_LO      4
`define ACC_ACQ_HI         3
`define ACC_ACQ_LO         2
`define ACC_TIMER_EN       1
`define ACC_EXT_EN         0
`define ACC_DONE_BIT       7
`define ACC_DMA_BIT        6
`define ACC_CONT_BIT       5
`define ACC_SINGLE_BIT     4
`define ACC_CONV_CLOCKS    5'd17
`define ACC_EXT_MIN_NS     100
`define ACC_CLK_PERIOD_NS  5
`define ACC_EXT_MIN_CYC    ((`ACC_EXT_MIN_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`endif

// ===== acc_clock_divider.v
// Converter clock enable divider
`timescale 1ns/1ps
module acc_clock_divider (
    input  wire       clk,
    input  wire       reset,
    input  wire [1:0] div_sel,
    output reg        tick
);
    reg  [2:0] count_reg;
    wire [2:0] limit = (3'h1 << div_sel) - 3'h1;

    always @(posedge clk) begin
        if (reset) begin
            count_reg <= 3'h0;
            tick      <= 1'b0;
        end else if (count_reg >= limit) begin
            count_reg <= 3'h0;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 3'h1;
            tick      <= 1'b0;
        end
    end
endmodule

// ===== acc_pin_filter.v
// Three-stage synchroniser and low-pulse detector for the start pin
`timescale 1ns/1ps
module acc_pin_filter #(
    parameter MIN_CYC = 20
) (
    input  wire clk,
    input  wire reset,
    input  wire pin_n,
    output reg  fall_pulse
);
    reg        s1_reg;
    reg        s2_reg;
    reg        s3_reg;
    reg        level_reg;
    reg  [7:0] low_cnt_reg;

    always @(posedge clk) begin
        if (reset) begin
            s1_reg      <= 1'b1;
            s2_reg      <= 1'b1;
            s3_reg      <= 1'b1;
            level_reg   <= 1'b1;
            low_cnt_reg <= 8'h00;
            fall_pulse  <= 1'b0;
        end else begin
            s1_reg     <= pin_n;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            fall_pulse <= 1'b0;
            if (s2_reg == s3_reg)
                level_reg <= s3_reg;
            // Fires once per low pulse, after it has stood long enough
            if (level_reg) begin
                low_cnt_reg <= 8'h00;
            end else if (low_cnt_reg < MIN_CYC[7:0]) begin
                low_cnt_reg <= low_cnt_reg + 8'h01;
                if (low_cnt_reg == MIN_CYC[7:0] - 8'h01)
                    fall_pulse <= 1'b1;
            end
        end
    end
endmodule

// ===== acc_conversion_control.v
// Converter control with AXI4-Lite register slave
`timescale 1ns/1ps
`include "acc_defines.vh"
module acc_conversion_control (
    input  wire        clk,
    input  wire        reset,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        convert_start_pin_n,
    input  wire        timer2_overflow,
    input  wire        irq_vector_ack,
    input  wire [11:0] sar_result,
    input  wire [3:0]  dma_channel_id,
    output reg         sar_sample,
    output reg         sar_convert,
    output reg  [3:0]  mux_channel,
    output reg         analog_power_on,
    output reg         analog_standby,
    output reg         reference_power_on,
    output reg  [11:0] cal_offset,
    output reg  [11:0] cal_gain,
    output reg         dma_write,
    output reg  [23:0] dma_address,
    output reg  [15:0] dma_data,
    output reg         conversion_done_irq,
    output wire        irq
);
    localparam ST_IDLE = 2'd0;
    localparam ST_ACQ  = 2'd1;
    localparam ST_CONV = 2'd2;

    reg  [7:0]  timing_reg;
    reg  [7:0]  chan_reg;
    reg  [15:0] data_reg;
    reg  [1:0]  irq_status_reg;
    reg  [1:0]  irq_mask_reg;
    reg  [23:0] dma_count_reg;
    reg  [23:0] dma_left_reg;
    reg  [1:0]  state_reg;
    reg  [4:0]  clk_cnt_reg;
    reg  [3:0]  conv_chan_reg;
    reg         timer_armed_reg;
    reg         aw_held_reg;
    reg         w_held_reg;
    reg  [11:0] awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    wire        tick;
    wire        ext_pulse;

    function [4:0] acq_clocks;
        input [1:0] code;
        begin
            acq_clocks = 5'h1 << code;
        end
    endfunction

    acc_clock_divider u_div (
        .clk     (clk),
        .reset   (reset),
        .div_sel (timing_reg[`ACC_CLKDIV_HI:`ACC_CLKDIV_LO]),
        .tick    (tick)
    );

    acc_pin_filter #(.MIN_CYC(`ACC_EXT_MIN_CYC)) u_pin (
        .clk        (clk),
        .reset      (reset),
        .pin_n      (convert_start_pin_n),
        .fall_pulse (ext_pulse)
    );

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_have  = aw_held_reg || (s_axi_awvalid && s_axi_awready);
    wire w_have   = w_held_reg || (s_axi_wvalid && s_axi_wready);
    wire [11:0] wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]  ws = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire do_write = aw_have && w_have;
    wire wr_lo    = do_write && ws[0];
    wire wr_hi2   = do_write && ws[1];

    wire busy     = (state_reg != ST_IDLE);
    wire dma_on   = chan_reg[`ACC_DMA_BIT];
    wire [1:0] md = timing_reg[`ACC_MODE_HI:`ACC_MODE_LO];
    wire timer_trig = timing_reg[`ACC_TIMER_EN] && timer2_overflow && timer_armed_reg;
    wire ext_trig   = timing_reg[`ACC_EXT_EN] && ext_pulse;
    wire start_req  = (md != 2'b00) && (chan_reg[`ACC_SINGLE_BIT] || chan_reg[`ACC_CONT_BIT]
                      || dma_on || timer_trig || ext_trig);
    wire finish     = (state_reg == ST_CONV) && tick && (clk_cnt_reg == `ACC_CONV_CLOCKS - 5'd1);
    wire dma_block_end = finish && dma_on && (dma_left_reg == 24'h000001);
    wire done_event = finish && (!dma_on || dma_block_end);
    // Power must already be up on the edge that starts acquisition
    wire busy_next  = busy ? !finish : start_req;
    wire [15:0] result_word = {conv_chan_reg, sar_result};

    assign irq = |(irq_status_reg & irq_mask_reg);

    always @(posedge clk) begin
        if (reset) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 12'h000;
            wdata_reg    <= 32'h00000000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !do_write) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !do_write) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (wa)
                    `ACC_OFF_TIMING, `ACC_OFF_CHANNEL, `ACC_OFF_CAL_OFFSET,
                    `ACC_OFF_CAL_GAIN, `ACC_OFF_IRQ_STATUS, `ACC_OFF_IRQ_MASK,
                    `ACC_OFF_DMA_ADDR, `ACC_OFF_DMA_COUNT, `ACC_OFF_DATA_LOW,
                    `ACC_OFF_DATA_HIGH: s_axi_bresp <= 2'b00;
                    default:            s_axi_bresp <= 2'b10;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel, one cycle after the address is taken
    always @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                `ACC_OFF_TIMING:     s_axi_rdata <= {24'h0, timing_reg};
                `ACC_OFF_CHANNEL:    s_axi_rdata <= {24'h0, chan_reg};
                `ACC_OFF_DATA_LOW:   s_axi_rdata <= {24'h0, data_reg[7:0]};
                `ACC_OFF_DATA_HIGH:  s_axi_rdata <= {24'h0, data_reg[15:8]};
                `ACC_OFF_CAL_OFFSET: s_axi_rdata <= {20'h0, cal_offset};
                `ACC_OFF_CAL_GAIN:   s_axi_rdata <= {20'h0, cal_gain};
                `ACC_OFF_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status_reg};
                `ACC_OFF_IRQ_MASK:   s_axi_rdata <= {30'h0, irq_mask_reg};
                `ACC_OFF_DMA_ADDR:   s_axi_rdata <= {8'h0, dma_address};
                `ACC_OFF_DMA_COUNT:  s_axi_rdata <= {8'h0, dma_count_reg};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Registers, sequencer and flags
    always @(posedge clk) begin
        if (reset) begin
            timing_reg          <= `ACC_TIMING_RESET;
            chan_reg            <= `ACC_CHANNEL_RESET;
            data_reg            <= 16'h0000;
            cal_offset          <= `ACC_CAL_OFFSET_RST;
            cal_gain            <= `ACC_CAL_GAIN_RST;
            irq_status_reg      <= 2'b00;
            irq_mask_reg        <= 2'b00;
            dma_address         <= 24'h000000;
            dma_count_reg       <= 24'h000000;
            dma_left_reg        <= 24'h000000;
            state_reg           <= ST_IDLE;
            clk_cnt_reg         <= 5'h00;
            conv_chan_reg       <= 4'h0;
            timer_armed_reg     <= 1'b0;
            sar_sample          <= 1'b0;
            sar_convert         <= 1'b0;
            mux_channel         <= 4'h0;
            dma_write           <= 1'b0;
            dma_data            <= 16'h0000;
            conversion_done_irq <= 1'b0;
            analog_power_on     <= 1'b0;
            analog_standby      <= 1'b0;
            reference_power_on  <= 1'b0;
        end else begin
            dma_write <= 1'b0;
            // Address stands with the strobe, then steps to the next sample
            if (dma_write)
                dma_address <= dma_address + 24'h000002;
            if (wr_lo) begin
                case (wa)
                    `ACC_OFF_TIMING:     timing_reg <= wd[7:0];
                    `ACC_OFF_CHANNEL:    chan_reg[6:0] <= wd[6:0];
                    `ACC_OFF_CAL_OFFSET: cal_offset[7:0] <= wd[7:0];
                    `ACC_OFF_CAL_GAIN:   cal_gain[7:0] <= wd[7:0];
                    `ACC_OFF_IRQ_MASK:   irq_mask_reg <= wd[1:0];
                    `ACC_OFF_DMA_ADDR:   dma_address[7:0] <= wd[7:0];
                    `ACC_OFF_DMA_COUNT:  dma_count_reg[7:0] <= wd[7:0];
                    default: ;
                endcase
            end
            if (wr_hi2) begin
                case (wa)
                    `ACC_OFF_CAL_OFFSET: cal_offset[11:8] <= wd[11:8];
                    `ACC_OFF_CAL_GAIN:   cal_gain[11:8] <= wd[11:8];
                    `ACC_OFF_DMA_ADDR:   dma_address[15:8] <= wd[15:8];
                    `ACC_OFF_DMA_COUNT:  dma_count_reg[15:8] <= wd[15:8];
                    default: ;
                endcase
            end
            if (do_write && ws[2]) begin
                if (wa == `ACC_OFF_DMA_ADDR) dma_address[23:16] <= wd[23:16];
                if (wa == `ACC_OFF_DMA_COUNT) dma_count_reg[23:16] <= wd[23:16];
            end
            // Arms on the first overflow so the second one starts
            if (!timing_reg[`ACC_TIMER_EN])
                timer_armed_reg <= 1'b0;
            else if (timer2_overflow)
                timer_armed_reg <= 1'b1;
            // Reference power always on; analog power follows mode and activity
            reference_power_on <= 1'b1;
            analog_power_on    <= (md == 2'b01) || (md[1] && busy_next);
            analog_standby     <= (md == 2'b11) && !busy_next;
            case (state_reg)
                ST_IDLE: begin
                    if (start_req) begin
                        state_reg     <= ST_ACQ;
                        clk_cnt_reg   <= 5'h00;
                        conv_chan_reg <= dma_on ? dma_channel_id
                                                : chan_reg[3:0];
                        mux_channel   <= dma_on ? dma_channel_id : chan_reg[3:0];
                        sar_sample    <= 1'b1;
                        if (dma_on && dma_left_reg == 24'h000000)
                            dma_left_reg <= dma_count_reg;
                    end
                end
                ST_ACQ: begin
                    // New triggers are not looked at here
                    if (tick) begin
                        if (clk_cnt_reg == acq_clocks(timing_reg[`ACC_ACQ_HI:`ACC_ACQ_LO]) - 5'd1) begin
                            state_reg   <= ST_CONV;
                            clk_cnt_reg <= 5'h00;
                            sar_sample  <= 1'b0;
                            sar_convert <= 1'b1;
                        end else begin
                            clk_cnt_reg <= clk_cnt_reg + 5'h01;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        if (finish) begin
                            state_reg   <= ST_IDLE;
                            sar_convert <= 1'b0;
                            data_reg    <= result_word;
                            chan_reg[`ACC_SINGLE_BIT] <= 1'b0;
                            if (dma_on) begin
                                dma_write    <= 1'b1;
                                dma_data     <= result_word;
                                dma_left_reg <= dma_left_reg - 24'h000001;
                                if (dma_block_end)
                                    chan_reg[`ACC_DMA_BIT] <= 1'b0;
                            end
                        end else begin
                            clk_cnt_reg <= clk_cnt_reg + 5'h01;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            // Done flag; a new event wins over the vector clear
            if (done_event)
                chan_reg[`ACC_DONE_BIT] <= 1'b1;
            else if (irq_vector_ack)
                chan_reg[`ACC_DONE_BIT] <= 1'b0;
            conversion_done_irq <= done_event || (chan_reg[`ACC_DONE_BIT] && !irq_vector_ack);
            // Sticky status: bit0 conversion done, bit1 DMA block end
            irq_status_reg <= (irq_status_reg
                & ~((do_write && ws[0] && wa == `ACC_OFF_IRQ_STATUS) ? wd[1:0] : 2'b00))
                | {dma_block_end, done_event};
        end
    end
endmodule

// ===== acc_conversion_control_assertions.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module acc_conversion_control_assertions (
    input wire        clk,
    input wire        reset,
    input wire        s_axi_awready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        sar_sample,
    input wire        sar_convert,
    input wire        analog_power_on,
    input wire        analog_standby,
    input wire        reference_power_on,
    input wire        dma_write
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Length of the current convert phase; 8 bits covers 17 ticks at divide 8
    logic [7:0] conv_len_reg;
    always @(posedge clk) begin
        if (reset || !sar_convert) conv_len_reg <= 8'h00;
        else conv_len_reg <= conv_len_reg + 8'h01;
    end

    sequence rd_stall; s_axi_rvalid && !s_axi_rready; endsequence
    sequence acq_end; $fell(sar_sample); endsequence
    sequence conv_end; $fell(sar_convert); endsequence

    conv_length_a: assert property (conv_end |-> conv_len_reg >= 8'h11)
        else $error("convert phase shorter than 17 cycles");
    acq_then_conv_a: assert property (acq_end |-> ##[0:8] sar_convert)
        else $error("no convert phase after acquisition");
    phase_excl_a: assert property (!(sar_sample && sar_convert))
        else $error("acquire and convert overlap");
    busy_power_a: assert property ((sar_sample || sar_convert) |->
        analog_power_on && !analog_standby)
        else $error("converter not fully powered while busy");
    ref_kept_on_a: assert property (!$past(reset) |-> reference_power_on)
        else $error("reference switched off");
    dma_strobe_a: assert property (dma_write |=> !dma_write)
        else $error("memory strobe longer than one cycle");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (rd_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped or changed");
    ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    aw_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");
endmodule

bind acc_conversion_control acc_conversion_control_assertions u_chk (.*);

// ===== acc_far_side.sv
// Far-side model: convert-start pin source and external capture memory
`timescale 1ns/1ps
module acc_far_side (
    input  wire        clk,
    output logic       convert_start_pin_n,
    output logic [3:0] dma_channel_id,
    input  wire        dma_write,
    input  wire [23:0] dma_address,
    input  wire [15:0] dma_data
);
    logic [23:0] aq[$];
    logic [15:0] dq[$];
    initial begin
        convert_start_pin_n = 1'b1;
        dma_channel_id = 4'h0;
    end
    // Pin idles high as if pulled up; callers keep n above 20 cycles
    task automatic pulse(input int n);
        @(posedge clk);
        convert_start_pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        convert_start_pin_n <= 1'b1;
    endtask
    // Identifier stored beside the samples in memory
    task automatic load_id(input logic [3:0] v);
        dma_channel_id <= v;
    endtask
    always @(posedge clk) begin
        if (dma_write) begin
            aq.push_back(dma_address);
            dq.push_back(dma_data);
        end
    end
endmodule

// ===== adc_conversion_control_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "acc_defines.vh"
module adc_conversion_control_bench;
    logic        clk = 1'b0, reset = 1'b1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0, sar_result = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 4'hf, dma_channel_id, mux_channel;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer2_overflow = 1'b0;
    logic        irq_vector_ack = 1'b0, convert_start_pin_n, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sar_sample, sar_convert;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
    logic        analog_power_on, analog_standby, reference_power_on, dma_write;
    logic        conversion_done_irq, irq, ps = 1'b0;
    logic [11:0] cal_offset, cal_gain, r;
    logic [23:0] dma_address;
    logic [15:0] dma_data;
    int          bad_count = 0, checks = 0, nconv = 0, ls, lc, n0, c;

    acc_conversion_control u_dut (.*);
    acc_far_side u_far (.*);

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        ps <= sar_sample;
        if (sar_sample && !ps) nconv <= nconv + 1;
    end

    function bit near(int got, int want, int d);
        return got > want - d && got <= want + d;
    endfunction
    function [7:0] hi_byte(input [3:0] ch, input [11:0] v);
        return {ch, v[11:8]};
    endfunction
    task automatic chk(input [31:0] got, input [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Both channels offered at once, each dropped once taken
    // St holds the response ready low for that many edges
    task automatic wr(input [11:0] a, input [31:0] d, input int st = 0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (st == 0);
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (st == 1) s_axi_bready <= 1'b1;
            if (st > 0) st--;
        end while (!(s_axi_bvalid && s_axi_bready));
        bs = s_axi_bresp;
    endtask
    task automatic rd(input [11:0] a, input int st = 0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (st == 0);
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (st == 1) s_axi_rready <= 1'b1;
            if (st > 0) st--;
        end while (!(s_axi_rvalid && s_axi_rready));
        q = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic tmr;
        timer2_overflow <= 1'b1;
        @(posedge clk);
        timer2_overflow <= 1'b0;
    endtask
    // Phase lengths sampled at the falling edge, where outputs are settled
    task automatic meas;
        ls = 0; lc = 0; n0 = 0;
        while (!sar_sample && n0 < 500) begin @(negedge clk); n0++; end
        while (sar_sample) begin @(negedge clk); ls++; end
        while (!sar_convert && n0 < 600) begin @(negedge clk); n0++; end
        while (sar_convert) begin @(negedge clk); lc++; end
        n0 = 0;
        while (!conversion_done_irq && n0 < 50) begin @(negedge clk); n0++; end
        @(posedge clk);
    endtask

    initial begin
        cyc(20000);
        bad_count++;
        close_out;
    end

    initial begin
        void'($urandom(95388));
        cyc(8);
        reset <= 1'b0;
        @(posedge clk);
        rd(`ACC_OFF_TIMING); chk(q, 32'h20);
        rd(`ACC_OFF_CHANNEL); chk(q, 32'h0);
        chk(cal_offset, 12'h800);
        chk(cal_gain, 12'h800);
        wr(`ACC_OFF_CAL_OFFSET, 32'h123); chk(cal_offset, 12'h123);
        chk(bs, 2'h0);
        rd(12'h200, 3); chk(rs, 2'h2);
        wr(12'h200, 32'h0, 3); chk(bs, 2'h2);
        chk(q, 32'h0);
        chk(reference_power_on, 1'b1);
        chk(analog_power_on, 1'b0);
        c = nconv; wr(`ACC_OFF_CHANNEL, 32'h10); cyc(100);
        chk(nconv - c, 0);
        wr(`ACC_OFF_CHANNEL, 32'h0);
        // Corner results 0 and full scale, random ones between; channel drawn at random from 0 to 8
        for (int i = 0; i < 4; i++) begin
            r = i == 0 ? 12'h000 : i == 3 ? 12'hfff : 12'($urandom);
            sar_result <= r;
            c = $urandom % 9;
            wr(`ACC_OFF_TIMING, 32'h40 | (i << 4) | (i << 2));
            wr(`ACC_OFF_IRQ_MASK, i & 1);
            wr(`ACC_OFF_CHANNEL, 32'h10 | c);
            meas;
            chk(conversion_done_irq, 1'b1);
            chk(mux_channel, c);
            chk(near(ls, 1 << (2 * i), 1 << i), 1);
            chk(near(lc, 17 << i, 1 << i), 1);
            chk(irq, i & 1);
            rd(`ACC_OFF_DATA_HIGH); chk(q, hi_byte(c, r));
            rd(`ACC_OFF_DATA_LOW); chk(q, r[7:0]);
            rd(`ACC_OFF_CHANNEL); chk(q, 8'h80 | c);
            wr(`ACC_OFF_IRQ_STATUS, 32'h1); chk(irq, 1'b0);
            irq_vector_ack <= 1'b1; @(posedge clk);
            irq_vector_ack <= 1'b0; @(posedge clk);
            chk(conversion_done_irq, 1'b0);
            rd(`ACC_OFF_CHANNEL); chk(q, c);
        end
        // Auto modes power the converter only while a conversion runs
        wr(`ACC_OFF_TIMING, 32'h80);
        cyc(2);
        chk(analog_power_on, 1'b0);
        wr(`ACC_OFF_CHANNEL, 32'h10);
        meas;
        chk(near(lc, 17, 1), 1);
        chk(analog_power_on, 1'b0);
        wr(`ACC_OFF_TIMING, 32'hc0);
        cyc(2);
        chk(analog_standby, 1'b1);
        chk(analog_power_on, 1'b0);
        // Second pin pulse lands inside a long conversion
        wr(`ACC_OFF_TIMING, 32'h71); c = nconv;
        u_far.pulse(30); cyc(5); u_far.pulse(30); cyc(300);
        chk(nconv - c, 1);
        wr(`ACC_OFF_TIMING, 32'h42); c = nconv;
        tmr; cyc(30); chk(nconv - c, 0);
        tmr; cyc(30); chk(nconv - c, 1);
        wr(`ACC_OFF_TIMING, 32'h40); cyc(30); c = nconv;
        wr(`ACC_OFF_CHANNEL, 32'h20); cyc(120);
        chk(nconv - c > 3, 1);
        wr(`ACC_OFF_CHANNEL, 32'h0); cyc(40);
        // Select bits point elsewhere; memory identifier must win
        r = 12'($urandom); sar_result <= r; u_far.load_id(4'h8);
        wr(`ACC_OFF_DMA_ADDR, 32'h100); wr(`ACC_OFF_DMA_COUNT, 32'h2);
        wr(`ACC_OFF_IRQ_STATUS, 32'h3); wr(`ACC_OFF_CHANNEL, 32'h43);
        n0 = 0;
        while (u_far.aq.size() < 2 && n0 < 400) begin @(posedge clk); n0++; end
        cyc(10);
        chk(u_far.aq.size(), 2);
        chk(u_far.aq[0], 24'h100);
        chk(u_far.aq[1], 24'h102);
        chk(u_far.dq[0], {4'h8, r});
        chk(u_far.dq[1], {4'h8, r});
        rd(`ACC_OFF_CHANNEL); chk(q[6], 1'b0);
        rd(`ACC_OFF_IRQ_STATUS); chk(q[1], 1'b1);
        close_out;
    end
endmodule
